// ### accel_ctrl.sv
// Power, link, self-test and data register control of the accelerometer
`timescale 1ns/100ps
module accel_ctrl
  import accel_pkg::*;
(
  input wire logic sys_clk_in,
  input wire logic rst_n_in,
  input wire logic [7:0] reg_addr_in,
  input wire logic reg_wr_in,
  input wire logic reg_rd_in,
  input wire logic [7:0] reg_wdata_in,
  output logic [7:0] reg_rdata_out,
  input wire logic signed [12:0] raw_x_in,
  input wire logic signed [12:0] raw_y_in,
  input wire logic signed [12:0] raw_z_in,
  input wire logic raw_valid_in,
  input wire logic activity_hit_in,
  input wire logic inactivity_hit_in,
  output logic [3:0] rate_code_out,
  output logic low_power_out,
  output logic measure_out,
  output logic asleep_out,
  output logic selftest_out,
  output logic selftest_ready_out,
  output logic selftest_settling_out,
  output logic activity_irq_out,
  output logic inactivity_irq_out,
  output logic data_ready_irq_out
);
  // ------------------------------------------------------------
  // Declarations
  // ------------------------------------------------------------
  typedef enum logic [1:0] {ARM_BOTH, ARM_INACT, ARM_ACT} arm_e;

  arm_e arm;
  logic [7:0] rate_reg;
  logic [7:0] power_reg;
  logic [7:0] format_reg;
  logic act_flag;
  logic inact_flag;
  logic ready_flag;
  logic asleep;
  logic [15:0] data_word [3];
  logic wr_rate;
  logic wr_power;
  logic wr_format;
  logic rd_src;
  logic rd_data;
  logic link_on;
  logic autosleep_on;
  logic measure_on;
  logic act_event;
  logic inact_event;
  logic ready_set;

  fmt_if fbus ();

  // ------------------------------------------------------------
  // Register decode
  // ------------------------------------------------------------
  function automatic logic hit(input logic [7:0] a, input logic [7:0] b);
    return a == b;
  endfunction

  assign wr_rate = reg_wr_in && hit(reg_addr_in, ADDR_RATE);
  assign wr_power = reg_wr_in && hit(reg_addr_in, ADDR_POWER);
  assign wr_format = reg_wr_in && hit(reg_addr_in, ADDR_FORMAT);
  assign rd_src = reg_rd_in && hit(reg_addr_in, ADDR_INT_SRC);
  assign rd_data = reg_rd_in && reg_addr_in >= ADDR_DATA_FIRST &&
    reg_addr_in <= ADDR_DATA_LAST;

  assign link_on = power_reg[PWR_LINK_BIT];
  assign autosleep_on = power_reg[PWR_AUTOSLEEP_BIT] && power_reg[PWR_SLEEP_BIT];
  assign measure_on = power_reg[PWR_MEASURE_BIT];

  // ------------------------------------------------------------
  // Writable registers
  // ------------------------------------------------------------
  always_ff @(posedge sys_clk_in) begin
    if (!rst_n_in) begin
      rate_reg <= RATE_RESET;
    end else if (wr_rate) begin
      rate_reg <= reg_wdata_in;
    end
  end

  always_ff @(posedge sys_clk_in) begin
    if (!rst_n_in) begin
      power_reg <= POWER_RESET;
    end else if (wr_power) begin
      power_reg <= reg_wdata_in;
    end
  end

  always_ff @(posedge sys_clk_in) begin
    if (!rst_n_in) begin
      format_reg <= FORMAT_RESET;
    end else if (wr_format) begin
      format_reg <= reg_wdata_in;
    end
  end

  // ------------------------------------------------------------
  // Activity and inactivity arming
  // ------------------------------------------------------------
  assign act_event = activity_hit_in && measure_on && (!link_on || arm == ARM_ACT);
  assign inact_event = inactivity_hit_in && measure_on && arm != ARM_ACT;

  always_ff @(posedge sys_clk_in) begin
    if (!rst_n_in) begin
      arm <= ARM_BOTH;
    end else if (!link_on) begin
      arm <= ARM_BOTH;
    end else begin
      unique case (arm)
        ARM_BOTH: begin
          arm <= ARM_INACT;
        end
        ARM_INACT: begin
          if (inact_event) begin
            arm <= ARM_ACT;
          end
        end
        ARM_ACT: begin
          if (act_event) begin
            arm <= ARM_INACT;
          end
        end
        default: begin
          arm <= ARM_BOTH;
        end
      endcase
    end
  end

  // ------------------------------------------------------------
  // Interrupt source flags
  // ------------------------------------------------------------
  always_ff @(posedge sys_clk_in) begin
    if (!rst_n_in) begin
      act_flag <= 1'b0;
    end else begin
      act_flag <= act_event || (act_flag && !rd_src);
    end
  end

  always_ff @(posedge sys_clk_in) begin
    if (!rst_n_in) begin
      inact_flag <= 1'b0;
    end else begin
      inact_flag <= inact_event || (inact_flag && !rd_src);
    end
  end

  assign ready_set = fbus.word_valid && !asleep;

  always_ff @(posedge sys_clk_in) begin
    if (!rst_n_in) begin
      ready_flag <= 1'b0;
    end else begin
      ready_flag <= ready_set || (ready_flag && !rd_data);
    end
  end

  // ------------------------------------------------------------
  // Automatic sleep
  // ------------------------------------------------------------
  always_ff @(posedge sys_clk_in) begin
    if (!rst_n_in) begin
      asleep <= 1'b0;
    end else if (!(autosleep_on && link_on)) begin
      asleep <= 1'b0;
    end else if (act_event) begin
      asleep <= 1'b0;
    end else if (inact_event && !act_flag) begin
      asleep <= 1'b1;
    end
  end

  always_ff @(posedge sys_clk_in) begin
    if (!rst_n_in) begin
      rate_code_out <= RATE_RESET[3:0];
    end else begin
      rate_code_out <= asleep ? SLEEP_RATE : rate_reg[3:0];
    end
  end

  always_ff @(posedge sys_clk_in) begin
    if (!rst_n_in) begin
      low_power_out <= 1'b0;
      measure_out <= 1'b0;
      asleep_out <= 1'b0;
    end else begin
      low_power_out <= rate_reg[RATE_LOW_POWER_BIT];
      measure_out <= measure_on;
      asleep_out <= asleep;
    end
  end

  // ------------------------------------------------------------
  // Self-test control
  // ------------------------------------------------------------
  always_ff @(posedge sys_clk_in) begin
    if (!rst_n_in) begin
      selftest_out <= 1'b0;
      selftest_ready_out <= 1'b0;
    end else begin
      selftest_out <= format_reg[FMT_SELFTEST_BIT];
      selftest_ready_out <= rate_reg[3:0] >= RATE_SELFTEST_MIN &&
        !rate_reg[RATE_LOW_POWER_BIT] &&
        format_reg[FMT_FULL_RESOLUTION_BIT_BIT] && format_reg[1:0] == RANGE_4G;
    end
  end

  selftest_settle u_settle (
    .sys_clk_in(sys_clk_in),
    .rst_n_in(rst_n_in),
    .selftest_in(selftest_out),
    .sample_in(raw_valid_in),
    .settling_out(selftest_settling_out)
  );

  // ------------------------------------------------------------
  // Output word formatting and data registers
  // ------------------------------------------------------------
  assign fbus.raw[0] = raw_x_in;
  assign fbus.raw[1] = raw_y_in;
  assign fbus.raw[2] = raw_z_in;
  assign fbus.raw_valid = raw_valid_in && measure_on && !asleep;
  assign fbus.justify = format_reg[FMT_JUSTIFY_BIT];
  assign fbus.full_resolution_bit = format_reg[FMT_FULL_RESOLUTION_BIT_BIT];
  assign fbus.range_code = format_reg[1:0];
  assign fbus.fast_rate = rate_code_out == RATE_3200 || rate_code_out == RATE_1600;

  sample_format u_format (
    .sys_clk_in(sys_clk_in),
    .rst_n_in(rst_n_in),
    .bus(fbus)
  );

  for (genvar g = 0; g < 3; g++) begin : g_data
    always_ff @(posedge sys_clk_in) begin
      if (!rst_n_in) begin
        data_word[g] <= 16'h0000;
      end else if (fbus.word_valid) begin
        data_word[g] <= fbus.word[g];
      end
    end
  end

  // ------------------------------------------------------------
  // Read port
  // ------------------------------------------------------------
  function automatic logic [7:0] data_byte(input logic [7:0] a,
    input logic [15:0] x, input logic [15:0] y, input logic [15:0] z);
    logic [2:0] idx;
    logic [15:0] w;
    idx = 3'(a - ADDR_DATA_FIRST);
    w = idx[2] ? z : (idx[1] ? y : x);
    return idx[0] ? w[15:8] : w[7:0];
  endfunction

  always_ff @(posedge sys_clk_in) begin
    if (!rst_n_in) begin
      reg_rdata_out <= 8'h00;
    end else if (reg_rd_in) begin
      if (hit(reg_addr_in, ADDR_RATE)) begin
        reg_rdata_out <= rate_reg;
      end else if (hit(reg_addr_in, ADDR_POWER)) begin
        reg_rdata_out <= power_reg;
      end else if (hit(reg_addr_in, ADDR_FORMAT)) begin
        reg_rdata_out <= format_reg;
      end else if (rd_src) begin
        reg_rdata_out <= 8'(({7'h00, ready_flag} << INT_READY_BIT) |
          ({7'h00, act_flag} << INT_ACT_BIT) | ({7'h00, inact_flag} << INT_INACT_BIT));
      end else if (rd_data) begin
        reg_rdata_out <= data_byte(reg_addr_in, data_word[0], data_word[1], data_word[2]);
      end else begin
        reg_rdata_out <= 8'h00;
      end
    end
  end

  assign activity_irq_out = act_flag;
  assign inactivity_irq_out = inact_flag;
  assign data_ready_irq_out = ready_flag;

  // ------------------------------------------------------------
  // Checks
  // ------------------------------------------------------------
  property p_link_inact;
    @(posedge sys_clk_in) disable iff (!rst_n_in)
    link_on && !wr_power && arm == ARM_INACT && inact_event |=> arm == ARM_ACT;
  endproperty
  a_link_inact: assert property (p_link_inact)
    else $error("Inactivity did not arm activity");

  property p_link_act;
    @(posedge sys_clk_in) disable iff (!rst_n_in)
    link_on && !wr_power && arm == ARM_ACT && act_event |=> arm == ARM_INACT;
  endproperty
  a_link_act: assert property (p_link_act)
    else $error("Activity did not arm inactivity");

  property p_link_no_act;
    @(posedge sys_clk_in) disable iff (!rst_n_in)
    link_on && arm != ARM_ACT && !act_flag |=> !activity_irq_out;
  endproperty
  a_link_no_act: assert property (p_link_no_act)
    else $error("Activity seen before inactivity in link mode");

  property p_src_clear;
    @(posedge sys_clk_in) disable iff (!rst_n_in)
    rd_src && !act_event && !inact_event |=> !activity_irq_out && !inactivity_irq_out;
  endproperty
  a_src_clear: assert property (p_src_clear)
    else $error("Source read did not clear flags");

  property p_no_sleep_pending;
    @(posedge sys_clk_in) disable iff (!rst_n_in)
    !asleep && act_flag |=> !asleep;
  endproperty
  a_no_sleep_pending: assert property (p_no_sleep_pending)
    else $error("Slept with activity pending");

  property p_sleep_entry;
    @(posedge sys_clk_in) disable iff (!rst_n_in)
    autosleep_on && link_on && !wr_power && inact_event && !act_flag && !act_event
      |=> asleep ##1 rate_code_out == SLEEP_RATE;
  endproperty
  a_sleep_entry: assert property (p_sleep_entry)
    else $error("Inactivity did not enter sleep");

  property p_wake;
    @(posedge sys_clk_in) disable iff (!rst_n_in)
    asleep && act_event && !reg_wr_in
      |=> !asleep && activity_irq_out ##1 rate_code_out == $past(rate_reg[3:0]);
  endproperty
  a_wake: assert property (p_wake)
    else $error("Activity did not wake and restore rate");

  property p_ready_flow;
    @(posedge sys_clk_in) disable iff (!rst_n_in)
    fbus.word_valid && !asleep |=> data_ready_irq_out;
  endproperty
  a_ready_flow: assert property (p_ready_flow)
    else $error("Sample ready lost while awake");

  property p_selftest_apply;
    @(posedge sys_clk_in) disable iff (!rst_n_in)
    wr_format |=> ##1 selftest_out == $past(reg_wdata_in[FMT_SELFTEST_BIT], 2);
  endproperty
  a_selftest_apply: assert property (p_selftest_apply)
    else $error("Self-test stimulus does not follow format bit");
endmodule

// ### accel_pkg.sv
// Constants shared by the accelerometer control logic
// Functional notes
// - With link set, activity is looked for only after inactivity was seen.
// - No automatic sleep while an activity flag is still uncleared.
// - Reduced power keeps sample-ready working; sleep is not for acquisition.
// - Sleep, autosleep and link set: inactivity drops to slow sleep rate.
// - Inactivity in link operation disarms inactivity and arms activity; in the first cycle after link is set it leaves only inactivity armed.
// - Activity while asleep restores programmed rate and raises activity flag.
// - Activity in link operation disarms activity and arms inactivity.
// - Rate code in bits 3:0; codes from 0x0A up are self-test ready.
// - Reduced-power bit must be zero for an accurate self-test.
// - Format bit 3 is full resolution; range code 3 is four g.
// - Format bit 7 applies self-test stimulus; clearing it removes it.
// - Outputs settle about four samples after self-test is switched on.
// - Fixed 10-bit mode scales counts with range; force stays constant.
// - At 3200 and 1600 Hz with half g or full resolution, LSB is zero.
// - Right aligned, the forced-zero bit is bit 0 of the low byte.
// - Left aligned, zero bit at 6, or 5, 4, 3 in full resolution.
// - Fast rates in fixed 10-bit at 1, 2, 4 g keep a live LSB.
package accel_pkg;
  // ------------------------------------------------------------
  // Register offsets
  // ------------------------------------------------------------
  localparam logic [7:0] ADDR_RATE = 8'h2C;
  localparam logic [7:0] ADDR_POWER = 8'h2D;
  localparam logic [7:0] ADDR_INT_SRC = 8'h30;
  localparam logic [7:0] ADDR_FORMAT = 8'h31;
  localparam logic [7:0] ADDR_DATA_FIRST = 8'h32;
  localparam logic [7:0] ADDR_DATA_LAST = 8'h37;
  // ------------------------------------------------------------
  // Field positions
  // ------------------------------------------------------------
  localparam int RATE_LOW_POWER_BIT = 4;
  localparam int PWR_LINK_BIT = 5;
  localparam int PWR_AUTOSLEEP_BIT = 4;
  localparam int PWR_MEASURE_BIT = 3;
  localparam int PWR_SLEEP_BIT = 2;
  localparam int FMT_SELFTEST_BIT = 7;
  localparam int FMT_FULL_RESOLUTION_BIT_BIT = 3;
  localparam int FMT_JUSTIFY_BIT = 2;
  localparam int INT_READY_BIT = 7;
  localparam int INT_ACT_BIT = 4;
  localparam int INT_INACT_BIT = 3;
  // ------------------------------------------------------------
  // Reset values and codes
  // ------------------------------------------------------------
  localparam logic [7:0] RATE_RESET = 8'h0A;
  localparam logic [7:0] POWER_RESET = 8'h00;
  localparam logic [7:0] FORMAT_RESET = 8'h00;
  localparam logic [3:0] RATE_SELFTEST_MIN = 4'hA;
  localparam logic [3:0] RATE_3200 = 4'hF;
  localparam logic [3:0] RATE_1600 = 4'hE;
  localparam logic [3:0] SLEEP_RATE = 4'h8;
  localparam logic [1:0] RANGE_HALF_G = 2'h0;
  localparam logic [1:0] RANGE_4G = 2'h3;
  localparam logic [2:0] SETTLE_SAMPLES = 3'h4;
endpackage

// ### fmt_if.sv
// Carrier between control logic and the output word formatter
`timescale 1ns/100ps
interface fmt_if;
  logic signed [12:0] raw [3];
  logic raw_valid;
  logic justify;
  logic full_resolution_bit;
  logic [1:0] range_code;
  logic fast_rate;
  logic [15:0] word [3];
  logic word_valid;
  modport fmt (input raw, raw_valid, justify, full_resolution_bit, range_code, fast_rate,
    output word, word_valid);
  modport ctl (output raw, raw_valid, justify, full_resolution_bit, range_code, fast_rate,
    input word, word_valid);
endinterface

// ### host_model.sv
// Host processor model driving the register port of the accelerometer
`timescale 1ns/100ps
module host_model
  import accel_pkg::*;
(
  input wire logic sys_clk_in,
  input wire logic [7:0] reg_rdata_in,
  output logic [7:0] reg_addr_out,
  output logic reg_wr_out,
  output logic reg_rd_out,
  output logic [7:0] reg_wdata_out
);
  initial begin
    reg_addr_out = 8'h00;
    reg_wr_out = 1'b0;
    reg_rd_out = 1'b0;
    reg_wdata_out = 8'h00;
  end
  // ------------------------------------------------------------
  // Register access
  // ------------------------------------------------------------
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    @(posedge sys_clk_in);
    reg_addr_out <= a;
    reg_wdata_out <= d;
    reg_wr_out <= 1'b1;
    @(posedge sys_clk_in);
    reg_wr_out <= 1'b0;
    reg_wdata_out <= ~d;
  endtask
  task automatic rd(input logic [7:0] a, output logic [7:0] d);
    @(posedge sys_clk_in);
    reg_addr_out <= a;
    reg_rd_out <= 1'b1;
    @(posedge sys_clk_in);
    reg_rd_out <= 1'b0;
    @(posedge sys_clk_in);
    #1;
    d = reg_rdata_in;
  endtask
  // ------------------------------------------------------------
  // Interrupt service and self-test setup
  // ------------------------------------------------------------
  task automatic service(output logic [7:0] d);
    rd(ADDR_INT_SRC, d);
  endtask
  task automatic st_config();
    wr(ADDR_RATE, 8'h0A);
    wr(ADDR_FORMAT, 8'h0B);
  endtask
endmodule

// ### sample_format.sv
// Output word scaling, alignment and fast-rate LSB forcing
`timescale 1ns/100ps
module sample_format
  import accel_pkg::*;
(
  input wire logic sys_clk_in,
  input wire logic rst_n_in,
  fmt_if.fmt bus
);
  // ------------------------------------------------------------
  // Word shaping
  // ------------------------------------------------------------
  function automatic logic [15:0] shape_word(input logic signed [12:0] v,
    input logic just, input logic fr, input logic [1:0] rng, input logic fast);
    logic signed [12:0] s;
    logic [15:0] w;
    s = fr ? v : (v >>> rng);
    if (fast && (fr || rng == RANGE_HALF_G)) begin
      s[0] = 1'b0;
    end
    w = {{3{s[12]}}, s};
    if (just) begin
      w = w << (4'h6 - (fr ? {2'h0, rng} : 4'h0));
    end
    return w;
  endfunction

  for (genvar g = 0; g < 3; g++) begin : g_axis
    always_ff @(posedge sys_clk_in) begin
      if (!rst_n_in) begin
        bus.word[g] <= 16'h0000;
      end else if (bus.raw_valid) begin
        bus.word[g] <= shape_word(bus.raw[g], bus.justify, bus.full_resolution_bit,
          bus.range_code, bus.fast_rate);
      end
    end
  end

  always_ff @(posedge sys_clk_in) begin
    if (!rst_n_in) begin
      bus.word_valid <= 1'b0;
    end else begin
      bus.word_valid <= bus.raw_valid;
    end
  end

  // ------------------------------------------------------------
  // Checks
  // ------------------------------------------------------------
  property p_right_lsb_zero;
    @(posedge sys_clk_in) disable iff (!rst_n_in)
    bus.raw_valid && bus.fast_rate && !bus.justify &&
    (bus.full_resolution_bit || bus.range_code == RANGE_HALF_G) |=> bus.word[0][0] == 1'b0;
  endproperty
  a_right_lsb_zero: assert property (p_right_lsb_zero)
    else $error("Right aligned fast-rate LSB not zero");

  property p_left_4g_lsb_zero;
    @(posedge sys_clk_in) disable iff (!rst_n_in)
    bus.raw_valid && bus.fast_rate && bus.justify && bus.full_resolution_bit &&
    bus.range_code == RANGE_4G |=> bus.word[1][3] == 1'b0;
  endproperty
  a_left_4g_lsb_zero: assert property (p_left_4g_lsb_zero)
    else $error("Left aligned four g LSB not zero");
endmodule

// ### selftest_settle.sv
// Counts samples while self-test output settles
`timescale 1ns/100ps
module selftest_settle
  import accel_pkg::*;
(
  input wire logic sys_clk_in,
  input wire logic rst_n_in,
  input wire logic selftest_in,
  input wire logic sample_in,
  output logic settling_out
);
  logic [2:0] count;
  logic [2:0] next_count;
  logic selftest_prev;

  always_comb begin
    next_count = count;
    if (!selftest_in) begin
      next_count = 3'h0;
    end else if (!selftest_prev) begin
      next_count = SETTLE_SAMPLES;
    end else if (sample_in && count != 3'h0) begin
      next_count = count - 3'h1;
    end
  end

  always_ff @(posedge sys_clk_in) begin
    if (!rst_n_in) begin
      count <= 3'h0;
      selftest_prev <= 1'b0;
      settling_out <= 1'b0;
    end else begin
      count <= next_count;
      selftest_prev <= selftest_in;
      settling_out <= next_count != 3'h0;
    end
  end

  property p_settle_start;
    @(posedge sys_clk_in) disable iff (!rst_n_in)
    selftest_in && !selftest_prev |=> settling_out && count == SETTLE_SAMPLES;
  endproperty
  a_settle_start: assert property (p_settle_start)
    else $error("Settling not flagged after self-test start");
endmodule

// ### tb.sv
// Self-checking testbench for the accelerometer control block
`timescale 1ns/100ps
module tb;
  import accel_pkg::*;
  logic sys_clk_in = 1'b0;
  logic rst_n_in = 1'b0;
  logic [7:0] reg_addr, reg_wdata, reg_rdata, d, lo, hi;
  logic reg_wr, reg_rd;
  logic signed [12:0] raw_x = 13'sd0;
  logic raw_valid = 1'b0;
  logic act_hit = 1'b0;
  logic inact_hit = 1'b0;
  logic [3:0] rate_code;
  logic low_power, measure, asleep, selftest, st_ready, st_settling;
  logic act_irq, inact_irq, ready_irq;
  logic [15:0] w;
  int n_errors = 0;
  int checked = 0;
  int s_off, s_on;
  logic [7:0] rates [3] = '{8'h0F, 8'h0E, 8'h0D};
  logic [7:0] cfg [6][3] = '{'{8'h09, 8'h0B, 8'h00}, '{8'h0A, 8'h0B, 8'h01},
    '{8'h0F, 8'h0B, 8'h01}, '{8'h1A, 8'h0B, 8'h00}, '{8'h0A, 8'h03, 8'h00},
    '{8'h0A, 8'h0A, 8'h00}};
  always #5 sys_clk_in = ~sys_clk_in;
  host_model host (.sys_clk_in(sys_clk_in), .reg_rdata_in(reg_rdata),
    .reg_addr_out(reg_addr), .reg_wr_out(reg_wr), .reg_rd_out(reg_rd),
    .reg_wdata_out(reg_wdata));
  accel_ctrl dut (.sys_clk_in(sys_clk_in), .rst_n_in(rst_n_in), .reg_addr_in(reg_addr),
    .reg_wr_in(reg_wr), .reg_rd_in(reg_rd), .reg_wdata_in(reg_wdata),
    .reg_rdata_out(reg_rdata), .raw_x_in(raw_x), .raw_y_in(-raw_x), .raw_z_in(raw_x),
    .raw_valid_in(raw_valid), .activity_hit_in(act_hit), .inactivity_hit_in(inact_hit),
    .rate_code_out(rate_code), .low_power_out(low_power), .measure_out(measure),
    .asleep_out(asleep), .selftest_out(selftest), .selftest_ready_out(st_ready),
    .selftest_settling_out(st_settling), .activity_irq_out(act_irq),
    .inactivity_irq_out(inact_irq), .data_ready_irq_out(ready_irq));
  // ------------------------------------------------------------
  // Compare, stimulus and verdict tasks
  // ------------------------------------------------------------
  task automatic check8(input string n, input logic [7:0] e, input logic [7:0] g);
    checked++;
    if (g !== e) begin
      $display("BAD %s expected %h seen %h", n, e, g);
      n_errors++;
    end
  endtask
  task automatic check1(input string n, input logic e, input logic g);
    checked++;
    if (g !== e) begin
      $display("BAD %s expected %b seen %b", n, e, g);
      n_errors++;
    end
  endtask
  task automatic hit(input int k);
    @(posedge sys_clk_in);
    raw_valid <= (k == 0);
    act_hit <= (k == 1);
    inact_hit <= (k == 2);
    @(posedge sys_clk_in);
    raw_valid <= 1'b0;
    act_hit <= 1'b0;
    inact_hit <= 1'b0;
    repeat (2) @(posedge sys_clk_in);
    #1;
  endtask
  task automatic settle();
    repeat (2) @(posedge sys_clk_in);
    #1;
  endtask
  function automatic logic [15:0] fmt_word(input logic [3:0] r, input logic [3:0] f);
    logic signed [15:0] v;
    v = 16'sd255;
    if (!f[3]) v = v >>> f[1:0];
    if ((r == RATE_3200 || r == RATE_1600) && (f[3] || f[1:0] == RANGE_HALF_G)) v[0] = 1'b0;
    if (f[2]) v = v << (6 - (f[3] ? f[1:0] : 2'h0));
    return v;
  endfunction
  task automatic avg_x(output int s);
    s = 0;
    repeat (10) begin
      hit(0);
      host.rd(ADDR_DATA_FIRST, lo);
      host.rd(ADDR_DATA_FIRST + 8'h01, hi);
      s += $signed({hi, lo});
    end
  endtask
  task automatic print_verdict();
    $display("Comparisons %0d mismatches %0d", checked, n_errors);
    if (n_errors == 0 && checked > 0) $display("Result: passed");
    else $display("Result: failed");
    $finish;
  endtask
  initial begin
    repeat (100000) @(posedge sys_clk_in);
    n_errors++;
    print_verdict();
  end
  // ------------------------------------------------------------
  // Main sequence
  // ------------------------------------------------------------
  initial begin
    repeat (8) @(posedge sys_clk_in);
    rst_n_in <= 1'b1;
    #1;
    check8("rate code", 8'h0A, rate_code);
    host.wr(ADDR_INT_SRC, 8'hFF);
    host.rd(ADDR_RATE, d);
    check8("rate reg", RATE_RESET, d);
    host.rd(ADDR_POWER, d);
    check8("power reg", POWER_RESET, d);
    host.rd(ADDR_FORMAT, d);
    check8("format reg", FORMAT_RESET, d);
    host.rd(8'h10, d);
    check8("unmapped", 8'h00, d);
    host.rd(ADDR_INT_SRC, d);
    check8("source", 8'h00, d);
    $display("test reset done");
    host.st_config();
    settle();
    check1("st ready", 1'b1, st_ready);
    foreach (cfg[i]) begin
      host.wr(ADDR_RATE, cfg[i][0]);
      host.wr(ADDR_FORMAT, cfg[i][1]);
      settle();
      check1("st ready", cfg[i][2][0], st_ready);
    end
    $display("test config done");
    host.wr(ADDR_POWER, 8'h08);
    host.wr(ADDR_FORMAT, 8'h8B);
    settle();
    check1("selftest", 1'b1, selftest);
    check1("measure", 1'b1, measure);
    check1("settling", 1'b1, st_settling);
    repeat (3) hit(0);
    check1("settling", 1'b1, st_settling);
    hit(0);
    check1("settling", 1'b0, st_settling);
    host.wr(ADDR_FORMAT, 8'h0B);
    settle();
    check1("selftest", 1'b0, selftest);
    $display("test selftest done");
    host.wr(ADDR_RATE, 8'h0C);
    host.wr(ADDR_POWER, 8'h3C);
    hit(1);
    check1("act irq", 1'b0, act_irq);
    hit(2);
    check1("inact irq", 1'b1, inact_irq);
    check1("asleep", 1'b1, asleep);
    check8("rate code", {4'h0, SLEEP_RATE}, {4'h0, rate_code});
    host.service(d);
    check8("source", 8'h08, d & 8'h18);
    hit(2);
    check1("inact irq", 1'b0, inact_irq);
    hit(1);
    check1("act irq", 1'b1, act_irq);
    check1("asleep", 1'b0, asleep);
    check8("rate code", 8'h0C, {4'h0, rate_code});
    hit(2);
    check1("inact irq", 1'b1, inact_irq);
    check1("asleep", 1'b0, asleep);
    host.service(d);
    check8("source", 8'h18, d & 8'h18);
    $display("test link done");
    host.wr(ADDR_POWER, 8'h08);
    host.wr(ADDR_RATE, 8'h1C);
    host.rd(ADDR_DATA_FIRST, d);
    @(posedge sys_clk_in) raw_x <= 13'sd255;
    hit(0);
    check1("low power", 1'b1, low_power);
    check1("ready irq", 1'b1, ready_irq);
    foreach (rates[i]) begin
      host.wr(ADDR_RATE, rates[i]);
      for (int f = 0; f < 16; f++) begin
        host.wr(ADDR_FORMAT, f[7:0]);
        hit(0);
        host.rd(ADDR_DATA_FIRST, lo);
        host.rd(ADDR_DATA_FIRST + 8'h01, hi);
        w = fmt_word(rates[i][3:0], f[3:0]);
        check8("x low", w[7:0], lo);
        check8("x high", w[15:8], hi);
      end
    end
    $display("test format done");
    host.st_config();
    @(posedge sys_clk_in) raw_x <= 13'sd300;
    avg_x(s_off);
    host.wr(ADDR_FORMAT, 8'h8B);
    @(posedge sys_clk_in) raw_x <= 13'sd500;
    repeat (4) hit(0);
    check1("settling", 1'b0, st_settling);
    avg_x(s_on);
    check8("selftest delta", 8'hC8, 8'((s_on - s_off) / 10));
    $display("test average done");
    print_verdict();
  end
endmodule
